// >>> gpio_pkg.sv
// gpio_pkg: register map, field layout, reset values and trigger modes
// shared by the gpio port block and its configurable interrupt unit.
// assumes a 32-bit AHB-Lite register bus with one aligned word per register.
package gpio_pkg;

    localparam int NUM_PORTS = 5;
    localparam int PORT_WIDTH = 8;
    localparam int NUM_CFG_INTS = 4;
    localparam int PIN_SEL_WIDTH = 3;
    localparam int ADDR_WIDTH = 8;

    // port numbers with interrupt duties
    localparam int CHANGE_PORT = 0;
    localparam int CFG_INT_PORT = 1;

    // register byte addresses
    localparam logic [ADDR_WIDTH-1:0] DIR_BASE = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] DATA_BASE = 8'h20;
    localparam logic [ADDR_WIDTH-1:0] CFG_INT_BASE = 8'h40;
    localparam logic [ADDR_WIDTH-1:0] PORT_INT_ADDR = 8'h50;
    localparam logic [ADDR_WIDTH-1:0] INT_STATUS_ADDR = 8'h54;
    localparam logic [ADDR_WIDTH-1:0] BLOCK_IEN_ADDR = 8'h58;
    localparam logic [ADDR_WIDTH-1:0] REG_STRIDE = 8'h04;

    // configurable interrupt register fields
    localparam int CFG_PIN_LSB = 0;
    localparam int CFG_MODE_LSB = 4;
    localparam int MODE_WIDTH = 3;

    // status register: bits 3..0 configurable interrupts, bit 4 port change
    localparam int STATUS_CHANGE_BIT = 4;

    // reset values
    localparam logic [PORT_WIDTH-1:0] DIR_RESET = 8'h00;
    localparam logic [PORT_WIDTH-1:0] DATA_RESET = 8'h00;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [MODE_WIDTH-1:0] {
        trigger_disabled = 3'h0,
        trigger_rising_edge = 3'h1,
        trigger_falling_edge = 3'h2,
        trigger_any_edge = 3'h3,
        trigger_high_level = 3'h4,
        trigger_low_level = 3'h5
    } trig_mode_t;

    localparam logic [MODE_WIDTH-1:0] LAST_MODE_CODE = 3'h5;

endpackage

// >>> gpio_int_if.sv
// gpio_int_if: carrier between the register file and one configurable
// interrupt unit. assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface gpio_int_if;
    import gpio_pkg::*;
    logic wr;
    logic [PIN_SEL_WIDTH-1:0] pin_sel_wr;
    trig_mode_t mode_wr;
    logic [PORT_WIDTH-1:0] pins;
    logic fire;
    logic [PIN_SEL_WIDTH-1:0] pin_sel;
    trig_mode_t mode;

    modport ctrl (output wr, output pin_sel_wr, output mode_wr, output pins,
        input fire, input pin_sel, input mode);
    modport unit (input wr, input pin_sel_wr, input mode_wr, input pins,
        output fire, output pin_sel, output mode);
endinterface

// >>> gpio_cfg_int.sv
// gpio_cfg_int: one configurable pin interrupt; watches a selected pin
// of an already synchronised port and disarms itself when it fires.
// assumes pins are synchronous to clk.
`timescale 1ns/1ps
module gpio_cfg_int
    import gpio_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register side
    gpio_int_if.unit bus
);

    logic level;
    logic prev_level;
    logic hit;

    assign level = bus.pins[bus.pin_sel];

    // trigger condition for the current mode
    always_comb begin
        unique case (bus.mode)
            trigger_rising_edge: hit = level & ~prev_level;
            trigger_falling_edge: hit = ~level & prev_level;
            trigger_any_edge: hit = level ^ prev_level;
            trigger_high_level: hit = level;
            trigger_low_level: hit = ~level;
            default: hit = 1'b0;
        endcase
    end

    // previous level; after a pin change the first compare sees the old pin,
    // so software should select the pin before arming an edge mode
    always_ff @(posedge clk) begin
        if (reset) begin
            prev_level <= 1'b0;
        end else begin
            prev_level <= level;
        end
    end

    // pin select
    always_ff @(posedge clk) begin
        if (reset) begin
            bus.pin_sel <= '0;
        end else if (bus.wr) begin
            bus.pin_sel <= bus.pin_sel_wr;
        end
    end

    // mode: a rewrite re-arms, a hit disarms; a rewrite wins so it is not lost
    always_ff @(posedge clk) begin
        if (reset) begin
            bus.mode <= trigger_disabled;
        end else if (bus.wr) begin
            bus.mode <= bus.mode_wr;
        end else if (hit) begin
            bus.mode <= trigger_disabled;
        end
    end

    // one-cycle fire pulse
    always_ff @(posedge clk) begin
        if (reset) begin
            bus.fire <= 1'b0;
        end else begin
            bus.fire <= hit;
        end
    end

endmodule // gpio_cfg_int

// >>> gpio_ports.sv
// gpio_ports: five byte-wide gpio ports behind an AHB-Lite slave, with a
// change interrupt on the first port and four configurable interrupts on
// the second. assumes pins are asynchronous to clk; one clock, sync reset.
//
// Summary of operation
// - per-pin direction mask, 1 output, 0 input
// - port read returns one byte of pins
// - successive byte writes drive out in order
// - four configurable interrupts on the second port
// - each selects one pin, 0 to 7
// - six trigger modes, fire on condition only
// - fired interrupt disarms until mode rewritten
// - armed or disabled state readable by software
// - no request out without block enable
// - forty pins as five ports of eight
// - first port: change interrupt; second: configurable; others none
// - change interrupt enable clears when it fires
`timescale 1ns/1ps
module gpio_ports
    import gpio_pkg::*;
#(
    parameter int PORTS = NUM_PORTS,
    parameter int WIDTH = PORT_WIDTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // pins
    input wire logic [PORTS*WIDTH-1:0] gpio_in,
    output logic [PORTS*WIDTH-1:0] gpio_out,
    output logic [PORTS*WIDTH-1:0] gpio_oe,
    // interrupt request to the processor
    output logic block_irq
);

    logic [PORTS*WIDTH-1:0] in_meta;
    logic [PORTS*WIDTH-1:0] in_sync;
    logic [WIDTH-1:0] prev_change_port;
    logic port_int_enable;
    logic block_interrupt_enable;
    logic [NUM_CFG_INTS:0] int_status;
    logic [NUM_CFG_INTS:0] int_events;
    logic wr_pending;
    logic rd_pending;
    logic [ADDR_WIDTH-1:0] dp_addr;
    logic wr_dir;
    logic wr_data;
    logic wr_cfg;
    logic [2:0] wr_port;
    logic [1:0] wr_int;
    logic [MODE_WIDTH-1:0] mode_field;
    logic change_hit;
    logic [31:0] next_hrdata;

    gpio_int_if cfg_bus [NUM_CFG_INTS] ();

    // two-flop synchroniser on every pin; only in_sync feeds logic
    always_ff @(posedge clk) begin
        if (reset) begin
            in_meta <= '0;
            in_sync <= '0;
        end else begin
            in_meta <= gpio_in;
            in_sync <= in_meta;
        end
    end

    // address phase capture; writes take no wait state, reads take one so
    // that a read right behind a write already sees the new value
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_pending <= 1'b0;
            rd_pending <= 1'b0;
            dp_addr <= '0;
        end else if (hready) begin
            wr_pending <= hsel & (htrans == HTRANS_NONSEQ) & hwrite;
            rd_pending <= hsel & (htrans == HTRANS_NONSEQ) & ~hwrite;
            dp_addr <= haddr[ADDR_WIDTH-1:0];
        end else begin
            rd_pending <= 1'b0;
        end
    end

    // wait state and data for reads; response is always OKAY
    always_ff @(posedge clk) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= '0;
        end else begin
            hresp <= 1'b0;
            hreadyout <= ~(hready & hsel & (htrans == HTRANS_NONSEQ) & ~hwrite);
            if (rd_pending) begin
                hrdata <= next_hrdata;
            end
        end
    end

    // data phase decode of writes
    always_comb begin
        wr_dir = 1'b0;
        wr_data = 1'b0;
        wr_cfg = 1'b0;
        wr_port = dp_addr[4:2];
        wr_int = dp_addr[3:2];
        if (wr_pending) begin
            wr_dir = (dp_addr >= DIR_BASE) && (dp_addr < DIR_BASE + 8'(PORTS) * REG_STRIDE);
            wr_data = (dp_addr >= DATA_BASE) && (dp_addr < DATA_BASE + 8'(PORTS) * REG_STRIDE);
            wr_cfg = (dp_addr >= CFG_INT_BASE)
                && (dp_addr < CFG_INT_BASE + 8'(NUM_CFG_INTS) * REG_STRIDE);
        end
    end

    // direction masks and output bytes; each write lands on the pins at once,
    // so back-to-back writes drive bytes in order, one per transfer
    always_ff @(posedge clk) begin
        if (reset) begin
            gpio_oe <= {PORTS{DIR_RESET}};
            gpio_out <= {PORTS{DATA_RESET}};
        end else begin
            for (int p = 0; p < PORTS; p++) begin
                if (wr_dir && wr_port == 3'(p)) begin
                    gpio_oe[p*WIDTH +: WIDTH] <= hwdata[WIDTH-1:0];
                end
                if (wr_data && wr_port == 3'(p)) begin
                    gpio_out[p*WIDTH +: WIDTH] <= hwdata[WIDTH-1:0];
                end
            end
        end
    end

    // configurable interrupt units on the second port
    assign mode_field = hwdata[CFG_MODE_LSB +: MODE_WIDTH];
    for (genvar i = 0; i < NUM_CFG_INTS; i++) begin : g_cfg
        assign cfg_bus[i].wr = wr_cfg && (wr_int == 2'(i));
        assign cfg_bus[i].pin_sel_wr = hwdata[CFG_PIN_LSB +: PIN_SEL_WIDTH];
        // illegal mode codes store as disabled
        assign cfg_bus[i].mode_wr = (mode_field <= LAST_MODE_CODE)
            ? trig_mode_t'(mode_field) : trigger_disabled;
        assign cfg_bus[i].pins = in_sync[CFG_INT_PORT*WIDTH +: WIDTH];
        assign int_events[i] = cfg_bus[i].fire;
        gpio_cfg_int u_cfg_int (
            .clk(clk),
            .reset(reset),
            .bus(cfg_bus[i])
        );
    end

    // any change on the first port while enabled
    assign change_hit = port_int_enable
        && (in_sync[CHANGE_PORT*WIDTH +: WIDTH] != prev_change_port);
    assign int_events[STATUS_CHANGE_BIT] = change_hit;

    always_ff @(posedge clk) begin
        if (reset) begin
            prev_change_port <= '0;
        end else begin
            prev_change_port <= in_sync[CHANGE_PORT*WIDTH +: WIDTH];
        end
    end

    // change interrupt enable: a write wins, otherwise a hit disarms it
    always_ff @(posedge clk) begin
        if (reset) begin
            port_int_enable <= 1'b0;
        end else if (wr_pending && dp_addr == PORT_INT_ADDR) begin
            port_int_enable <= hwdata[0];
        end else if (change_hit) begin
            port_int_enable <= 1'b0;
        end
    end

    // top-level enable for the whole block
    always_ff @(posedge clk) begin
        if (reset) begin
            block_interrupt_enable <= 1'b0;
        end else if (wr_pending && dp_addr == BLOCK_IEN_ADDR) begin
            block_interrupt_enable <= hwdata[0];
        end
    end

    // sticky status, write one to clear; a new event wins over its clear
    always_ff @(posedge clk) begin
        if (reset) begin
            int_status <= '0;
        end else if (wr_pending && dp_addr == INT_STATUS_ADDR) begin
            int_status <= (int_status & ~hwdata[NUM_CFG_INTS:0]) | int_events;
        end else begin
            int_status <= int_status | int_events;
        end
    end

    // request to the processor only while the block enable is set
    always_ff @(posedge clk) begin
        if (reset) begin
            block_irq <= 1'b0;
        end else begin
            block_irq <= block_interrupt_enable && (|int_status);
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        logic [ADDR_WIDTH-1:0] a;
        a = dp_addr;
        next_hrdata = '0;
        for (int p = 0; p < PORTS; p++) begin
            if (a == DIR_BASE + 8'(p) * REG_STRIDE) begin
                next_hrdata[WIDTH-1:0] = gpio_oe[p*WIDTH +: WIDTH];
            end
            if (a == DATA_BASE + 8'(p) * REG_STRIDE) begin
                next_hrdata[WIDTH-1:0] = in_sync[p*WIDTH +: WIDTH];
            end
        end
        for (int i = 0; i < NUM_CFG_INTS; i++) begin
            if (a == CFG_INT_BASE + 8'(i) * REG_STRIDE) begin
                next_hrdata[CFG_PIN_LSB +: PIN_SEL_WIDTH] = cfg_pin_sel(i);
                next_hrdata[CFG_MODE_LSB +: MODE_WIDTH] = cfg_mode(i);
            end
        end
        if (a == PORT_INT_ADDR) begin
            next_hrdata[0] = port_int_enable;
        end
        if (a == INT_STATUS_ADDR) begin
            next_hrdata[NUM_CFG_INTS:0] = int_status;
        end
        if (a == BLOCK_IEN_ADDR) begin
            next_hrdata[0] = block_interrupt_enable;
        end
    end

    // flattened views of the unit readback for the read mux
    logic [NUM_CFG_INTS*PIN_SEL_WIDTH-1:0] sel_flat;
    logic [NUM_CFG_INTS*MODE_WIDTH-1:0] mode_flat;
    for (genvar i = 0; i < NUM_CFG_INTS; i++) begin : g_rb
        assign sel_flat[i*PIN_SEL_WIDTH +: PIN_SEL_WIDTH] = cfg_bus[i].pin_sel;
        assign mode_flat[i*MODE_WIDTH +: MODE_WIDTH] = cfg_bus[i].mode;
    end

    function automatic logic [PIN_SEL_WIDTH-1:0] cfg_pin_sel(input int i);
        return sel_flat[i*PIN_SEL_WIDTH +: PIN_SEL_WIDTH];
    endfunction

    function automatic logic [MODE_WIDTH-1:0] cfg_mode(input int i);
        return mode_flat[i*MODE_WIDTH +: MODE_WIDTH];
    endfunction

endmodule // gpio_ports

// >>> gpio_ports_chk.sv
// gpio_ports_chk: port-level assertions for gpio_ports.
// assumes one clock, sync reset and a single bus master.
`timescale 1ns/1ps
module gpio_ports_chk import gpio_pkg::*; #(
    parameter int PORTS = NUM_PORTS,
    parameter int WIDTH = PORT_WIDTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // pins and request
    input wire logic [PORTS*WIDTH-1:0] gpio_in,
    input wire logic [PORTS*WIDTH-1:0] gpio_out,
    input wire logic [PORTS*WIDTH-1:0] gpio_oe,
    input wire logic block_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic wph;
    logic ien;
    logic [7:0] wad;
    wire take = hsel && hready && htrans == HTRANS_NONSEQ;
    // write data phase tracker
    always_ff @(posedge clk) begin
        if (reset) begin
            wph <= 1'b0;
            wad <= 8'h00;
        end else begin
            wph <= take && hwrite;
            wad <= haddr[7:0];
        end
    end
    // shadow of the block enable, since it is not visible at the pins
    always_ff @(posedge clk) begin
        if (reset) ien <= 1'b0;
        else if (wph && wad == BLOCK_IEN_ADDR) ien <= hwdata[0];
    end
    sequence rd_take; take && !hwrite; endsequence
    sequence rd_wait; !hreadyout ##1 hreadyout; endsequence
    AST_READ_WAIT: assert property (rd_take |=> rd_wait)
        else $error("read wait state wrong");
    AST_RD_BYTE: assert property (rd_take |-> ##2 hrdata[31:8] == 24'h000000)
        else $error("read data wider than a byte");
    AST_WR_NOWAIT: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    AST_RST_VALUES: assert property ($fell(reset) |-> !gpio_oe && !gpio_out && !block_irq)
        else $error("outputs not cleared by reset");
    AST_IRQ_GATE: assert property (!ien [*2] |-> !block_irq)
        else $error("request without block enable");
    AST_DIR_WR: assert property (wph && wad == DIR_BASE |=>
        gpio_oe[7:0] == $past(hwdata[7:0]))
        else $error("direction mask not applied");
    AST_DATA_WR: assert property (wph && wad == DATA_BASE |=>
        gpio_out[7:0] == $past(hwdata[7:0]))
        else $error("output byte not driven");
    AST_OE_HOLD: assert property ($changed(gpio_oe) |-> $past(wph))
        else $error("direction changed without a write");
endmodule // gpio_ports_chk

bind gpio_ports gpio_ports_chk #(.PORTS(PORTS), .WIDTH(WIDTH)) u_chk (.clk(clk), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .block_irq(block_irq));

// >>> gpio_pin_model.sv
// gpio_pin_model: the outside world on the pins.
// assumes the bench chooses the level offered to undriven pins.
`timescale 1ns/1ps
module gpio_pin_model import gpio_pkg::*; (
    // levels from the block
    input wire logic [NUM_PORTS*PORT_WIDTH-1:0] gpio_out,
    input wire logic [NUM_PORTS*PORT_WIDTH-1:0] gpio_oe,
    // level offered from outside
    input wire logic [NUM_PORTS*PORT_WIDTH-1:0] ext_level,
    // what the block sees
    output logic [NUM_PORTS*PORT_WIDTH-1:0] gpio_in
);
    // a driven pin reads back its own output
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_level);
endmodule // gpio_pin_model

// >>> tb_top.sv
// tb_top: scripted bus tests of gpio_ports with a pin model.
// assumes one 200 MHz clock and this bench as the only master.
`timescale 1ns/1ps
module tb_top import gpio_pkg::*;;
    logic clk, reset, hsel, hwrite, hreadyout, hresp, block_irq, lvl;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [39:0] gpio_in, gpio_out, gpio_oe, ext;
    logic [7:0] seen_q[$];
    logic [7:0] burst[3] = '{8'h3C, 8'hC3, 8'h00};
    int err_count, tests_run, cycles, pin;
    gpio_ports uut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .block_irq(block_irq));
    gpio_pin_model pins (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_level(ext),
        .gpio_in(gpio_in));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // every new port 0 output byte, in order
    always @(gpio_out[7:0]) seen_q.push_back(gpio_out[7:0]);
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one transfer; holds each phase until hready is seen high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hwrite <= w;
        haddr <= {24'h000000, a};
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask
    initial begin
        {reset, hsel, hsize} = {1'b1, 1'b1, 3'h2};
        {hwrite, haddr, htrans, hwdata, ext} = '0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // reset state
        chk(gpio_oe, 40'h0);
        for (int p = 0; p < 5; p++) rdchk(DIR_BASE + 8'(4*p), 32'h0);
        for (int n = 0; n < 4; n++) rdchk(CFG_INT_BASE + 8'(4*n), 32'h0);
        rdchk(PORT_INT_ADDR, 32'h0);
        rdchk(INT_STATUS_ADDR, 32'h0);
        rdchk(BLOCK_IEN_ADDR, 32'h0);
        chk(block_irq, 1'b0);
        rdchk(8'hFC, 32'h0);
        // mixed directions on all five ports
        ext <= 40'hC3A55A3C96;
        for (int p = 0; p < 5; p++) begin
            bus(1'b1, DIR_BASE + 8'(4*p), 32'(8'hF0 >> p));
            bus(1'b1, DATA_BASE + 8'(4*p), 32'h5A);
            repeat (4) @(posedge clk);
            rdchk(DIR_BASE + 8'(4*p), 32'(8'hF0 >> p));
            chk(gpio_oe[8*p+:8], 8'hF0 >> p);
            chk(gpio_out[8*p+:8], 8'h5A);
            rdchk(DATA_BASE + 8'(4*p),
                32'((8'h5A & (8'hF0 >> p)) | (ext[8*p+:8] & ~(8'hF0 >> p))));
        end
        // back-to-back burst on port 0
        bus(1'b1, DIR_BASE, 32'hFF);
        seen_q.delete();
        for (int i = 0; i < 3; i++) bus(1'b1, DATA_BASE, 32'(burst[i]));
        @(posedge clk);
        chk(seen_q.size(), 3);
        for (int i = 0; i < 3; i++) chk(seen_q[i], burst[i]);
        // port 0 change interrupt; port 2 must stay silent
        bus(1'b1, DIR_BASE, 32'h0);
        bus(1'b1, BLOCK_IEN_ADDR, 32'h1);
        bus(1'b1, PORT_INT_ADDR, 32'h1);
        rdchk(PORT_INT_ADDR, 32'h1);
        ext[16] <= ~ext[16];
        repeat (8) @(posedge clk);
        rdchk(INT_STATUS_ADDR, 32'h0);
        ext[3] <= ~ext[3];
        repeat (8) @(posedge clk);
        chk(block_irq, 1'b1);
        rdchk(INT_STATUS_ADDR, 32'h10);
        rdchk(PORT_INT_ADDR, 32'h0);
        bus(1'b1, INT_STATUS_ADDR, 32'h10);
        ext[3] <= ~ext[3];
        repeat (8) @(posedge clk);
        rdchk(INT_STATUS_ADDR, 32'h0);
        chk(block_irq, 1'b0);
        // a fired event stays held back while the block enable is off
        bus(1'b1, BLOCK_IEN_ADDR, 32'h0);
        bus(1'b1, DIR_BASE + 8'h04, 32'h0);
        ext[15:8] <= 8'h00;
        bus(1'b1, CFG_INT_BASE, 32'h10);
        ext[8] <= 1'b1;
        repeat (8) @(posedge clk);
        rdchk(INT_STATUS_ADDR, 32'h1);
        chk(block_irq, 1'b0);
        bus(1'b1, BLOCK_IEN_ADDR, 32'h1);
        repeat (3) @(posedge clk);
        chk(block_irq, 1'b1);
        bus(1'b1, INT_STATUS_ADDR, 32'h1);
        ext[8] <= 1'b0;
        // every interrupt in every active mode, rearmed by rewriting the mode
        for (int n = 0; n < 4; n++) begin
            for (int m = 1; m < 6; m++) begin
                pin = 2 * n + 1;
                lvl = (m == 2 || m == 5);
                ext[8+pin] <= lvl;
                repeat (4) @(posedge clk);
                bus(1'b1, CFG_INT_BASE + 8'(4*n), 32'(m*16 + pin));
                bus(1'b0, CFG_INT_BASE + 8'(4*n), 32'h0);
                chk(rd[6:4], m[2:0]);
                chk(rd[2:0], pin[2:0]);
                ext[7+pin] <= 1'b1;
                repeat (6) @(posedge clk);
                ext[7+pin] <= 1'b0;
                repeat (6) @(posedge clk);
                rdchk(INT_STATUS_ADDR, 32'h0);
                ext[8+pin] <= ~lvl;
                repeat (8) @(posedge clk);
                chk(block_irq, 1'b1);
                rdchk(INT_STATUS_ADDR, 32'(1 << n));
                bus(1'b0, CFG_INT_BASE + 8'(4*n), 32'h0);
                chk(rd[6:4], 3'h0);
                bus(1'b1, INT_STATUS_ADDR, 32'(1 << n));
                repeat (6) @(posedge clk);
                rdchk(INT_STATUS_ADDR, 32'h0);
            end
        end
        // disabled mode ignores its pin
        bus(1'b1, CFG_INT_BASE, 32'h1);
        ext[9] <= ~ext[9];
        repeat (8) @(posedge clk);
        rdchk(INT_STATUS_ADDR, 32'h0);
        // an unknown mode code must not arm the unit
        bus(1'b1, CFG_INT_BASE + 8'h04, 32'h63);
        bus(1'b0, CFG_INT_BASE + 8'h04, 32'h0);
        chk(rd[6:4], 3'h0);
        chk(rd[2:0], 3'h3);
        // a transfer without select leaves the registers alone
        hsel <= 1'b0;
        bus(1'b1, DIR_BASE, 32'hFF);
        hsel <= 1'b1;
        rdchk(DIR_BASE, 32'h0);
        chk(hresp, 1'b0);
        tally_and_finish();
    end
endmodule // tb_top
